// ### bench/tb_vwat_top.sv
// self-checking bench for the window translator
`timescale 1ns/1ps
module tb_vwat_top;
	import vwat_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] node_id = 4'hC;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	vwat_cpu_req_t cpu_req;
	vwat_cpu_rsp_t cpu_rsp;
	vwat_dma_req_t dma_req;
	vwat_dma_rsp_t dma_rsp;
	vwat_cpu_req_t c;
	vwat_dma_req_t d;
	int mismatches = 0;
	int checked = 0;
	logic [31:0] offs [32];
	logic [3:0] nodes [3] = '{4'hC, 4'h8, 4'h0};
	logic [5:0] ams [6] = '{6'h09, 6'h0D, 6'h39, 6'h3D, 6'h29, 6'h2D};
	logic [2:0] mode;
	logic ext_en;
	logic std_en;
	logic a30;
	logic [31:0] r;
	logic e;
	logic pcv;
	logic pdv;
	logic [38:0] pec;
	logic [40:0] ped;
	logic [7:0] n_cv;
	logic [7:0] n_cr;
	logic [7:0] n_dc;
	logic [7:0] n_dr;
	always #5 pclk = ~pclk;
	vwat_far i_vwat_far (.cpu_req(cpu_req), .dma_req(dma_req));
	vwat_top i_vwat_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.node_id(node_id), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .dma_req(dma_req), .dma_rsp(dma_rsp));
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 9 && pready !== 1'b1; n++)
			@(posedge pclk);
		if (pready !== 1'b1)
		begin
			mismatches++;
			final_report();
		end
		else
		begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb
	function automatic logic [38:0] exp_cpu(input logic lw, input logic [31:0] a);
		logic [31:0] o;
		if (a30)
			a[31:30] = 2'b11;
		o = offs[a[24:20]];
		if (a[31:23] inside {[9'h1C0:9'h1C2]})
			return {3'h1, 36'h0};
		if (a[31:19] == {9'h1C3, node_id} && !(node_id inside {4'h0, 4'hF}))
			return lw ? {3'h2, 13'h0, a[18:0], 4'h0} : {3'h4, 36'h0};
		if (a[31:25] == {3'h7, node_id} && node_id inside {[4'h1:4'h5], [4'hA:4'hE]})
			return lw ? {3'h3, o[31:20], a[19:0], o[3:0]} : {3'h4, 36'h0};
		return '0;
	endfunction : exp_cpu
	function automatic logic [40:0] exp_dma(input logic [5:0] am, input logic [31:0] a);
		if (mode != 3'h0)
			return '0;
		if (am[5:3] == 3'h1 && ext_en && a[31:29] == 3'h0)
			return {1'b1, 11'h0, a[28:0]};
		if (am[5:3] == 3'h7 && std_en && !a[23])
			return {1'b1, 16'h0, a[23:0]};
		return '0;
	endfunction : exp_dma
	initial
	begin
		void'($urandom(32'hB3A9));
		for (int k = 0; k < 3; k++)
		begin
			repeat (3) @(posedge pclk);
			presetn <= 1'b1;
			repeat (2) @(posedge pclk);
			apb(1'b0, 12'h000, 32'h0);
			chk("util", r, 32'h0);
			apb(1'b0, 12'h008, 32'h0);
			chk("stat", r[9:0], {6'h0, node_id});
			apb(1'b0, 12'h010, 32'h0);
			chk("unmapped", {e, r}, {1'b1, 32'h0});
			apb(1'b1, 12'h008, 32'h0);
			chk("ro write", e, 1'b1);
			for (int i = 0; i < 32; i++)
			begin
				offs[i] = $urandom & 32'hFFF0_000F;
				apb(1'b1, 12'h080 + 12'(i * 4), offs[i]);
				apb(1'b0, 12'h080 + 12'(i * 4), 32'h0);
				chk("offset", r, offs[i]);
			end
			for (int p = 0; p < 8; p++)
			begin
				mode = p < 4 ? 3'h0 : 3'(p - 3);
				{a30, std_en, ext_en} = 3'(p);
				apb(1'b1, 12'h000, {12'h0, mode, 16'h0, a30});
				apb(1'b1, 12'h004, {30'h0, std_en, ext_en});
				// any write to the count word clears counts and refusal flags
				apb(1'b1, 12'h00C, 32'h0);
				chk("clear", e, 1'b0);
				n_cv = 8'h00;
				n_cr = 8'h00;
				n_dc = 8'h00;
				n_dr = 8'h00;
				apb(1'b0, 12'h008, 32'h0);
				chk("mode", r[6:4], mode);
				for (int i = 0; i <= 40; i++)
				begin
					c.valid = i < 40 && $urandom % 8 != 0;
					c.addr = $urandom;
					case ($urandom % 4)
						0: c.addr[31:25] = {3'h7, node_id};
						1: c.addr[31:19] = {9'h1C3, node_id};
						2: c.addr[31:23] = 9'h1C0 + 9'($urandom % 3);
						default: ;
					endcase
					if (a30)
						c.addr[31:30] = 2'b00;
					c.longword = $urandom % 4 != 0;
					d.valid = i < 40 && $urandom % 8 != 0;
					d.am = $urandom % 8 == 0 ? 6'($urandom) : ams[$urandom % 6];
					d.addr = $urandom;
					if ($urandom % 2)
						d.addr[31:29] = 3'h0;
					if ($urandom % 2)
						d.addr[23] = 1'b0;
					i_vwat_far.send(c, d);
					@(posedge pclk);
					if (i > 0)
					begin
						chk("cpu valid", cpu_rsp.valid, pcv);
						chk("dma valid", dma_rsp.valid, pdv);
						if (pcv)
							chk("cpu rsp", cpu_rsp[38:0], pec);
						if (pdv)
							chk("dma rsp", dma_rsp[40:0], ped);
						n_cv = n_cv + {7'h00, pcv && pec[38:36] == 3'h3};
						n_cr = n_cr + {7'h00, pcv && pec[38:36] == 3'h4};
						n_dc = n_dc + {7'h00, pdv && ped[40]};
						n_dr = n_dr + {7'h00, pdv && !ped[40]};
					end
					pcv = c.valid;
					pdv = d.valid;
					pec = exp_cpu(c.longword, c.addr);
					ped = exp_dma(d.am, d.addr);
				end
				apb(1'b0, 12'h00C, 32'h0);
				chk("counts", r, {n_dr, n_dc, n_cr, n_cv});
				apb(1'b0, 12'h008, 32'h0);
				chk("seen", r[9:8], {n_dr != 8'h00, n_cr != 8'h00});
			end
			presetn <= 1'b0;
			node_id <= nodes[(k + 1) % 3];
		end
		final_report();
	end
endmodule : tb_vwat_top

// ### bench/vwat_far.sv
// host and vme master stand-in driving the request ports
`timescale 1ns/1ps
module vwat_far
	import vwat_pkg::*;
(
	output vwat_cpu_req_t cpu_req,
	output vwat_dma_req_t dma_req
);
	initial
	begin
		cpu_req = '0;
		dma_req = '0;
	end
	// idle buses show a moving pattern, never a stale address
	task automatic send(input vwat_cpu_req_t c, input vwat_dma_req_t d);
		if (!c.valid)
			c.addr = ~cpu_req.addr;
		if (!d.valid)
			d.addr = ~dma_req.addr;
		cpu_req <= c;
		dma_req <= d;
	endtask : send
endmodule : vwat_far

// ### bench/vwat_top_asserts.sv
// assertions on the window translator ports
`timescale 1ns/1ps
module vwat_top_asserts
	import vwat_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [3:0] node_id,
	input vwat_cpu_req_t cpu_req,
	input vwat_cpu_rsp_t cpu_rsp,
	input vwat_dma_req_t dma_req,
	input vwat_dma_rsp_t dma_rsp
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		pready ##1 !pready;
	endsequence
	a_apb_answer: assert property (s_setup |=> s_access)
		else $error("apb answer wrong");
	a_dma_answer: assert property (dma_req.valid |=> dma_rsp.valid)
		else $error("dma answer missing");
	a_short_never: assert property (dma_req.valid && dma_req.am inside {6'h29, 6'h2D} |=> !dma_rsp.claim)
		else $error("short cycle claimed");
	a_ext_top: assert property (
		dma_req.valid && dma_req.am[5:3] == 3'h1 && dma_req.addr[31:29] != 3'h0 |=> !dma_rsp.claim)
		else $error("extended high address claimed");
	a_std_high: assert property (dma_req.valid && dma_req.am[5:3] == 3'h7 && dma_req.addr[23] |=> !dma_rsp.claim)
		else $error("standard high address claimed");
	a_reject_zero: assert property (dma_rsp.valid && !dma_rsp.claim |-> dma_rsp.sys_addr == 40'h0)
		else $error("unclaimed address not zero");
	a_claim_top: assert property (dma_rsp.claim |-> dma_rsp.sys_addr[39:29] == 11'h0)
		else $error("upper system bits set");
	a_cpu_low: assert property (
		cpu_rsp.valid && cpu_rsp.kind == VWAT_CPU_VME |-> cpu_rsp.vme_addr[19:0] == $past(cpu_req.addr[19:0]))
		else $error("low vme bits differ");
	a_cpu_window: assert property (
		cpu_req.valid && cpu_req.addr[28:25] != node_id |=> cpu_rsp.kind != VWAT_CPU_VME)
		else $error("foreign window answered");
endmodule : vwat_top_asserts
bind vwat_top vwat_top_asserts i_vwat_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .node_id(node_id), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
	.dma_req(dma_req), .dma_rsp(dma_rsp));

// ### design/vwat_cpu_dec.sv
// cpu-side decode of a normalised 32-bit system address
`timescale 1ns/1ps
`include "vwat_regs.svh"
module vwat_cpu_dec
	import vwat_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic longword,
	input wire logic [3:0] node,
	output vwat_cpu_kind_t kind
);
	logic priv_hit;
	logic csr_hit;
	logic win_hit;
	logic win_exists;

	assign priv_hit = (addr[31:23] >= `VWAT_PRIV_FIRST) && (addr[31:23] <= `VWAT_PRIV_LAST);
	assign csr_hit = (node != 4'h0) && (node != 4'hF)
		&& (addr[31:19] == (`VWAT_NODESP_BASE + {9'h000, node}));
	// slots 6 to 9 carry no connector, so they own no window
	assign win_exists = ((node >= 4'h1) && (node <= 4'h5)) || ((node >= 4'hA) && (node <= 4'hE));
	assign win_hit = win_exists && (addr[31:25] == (`VWAT_WIN_BASE + {3'h0, node}));

	always_comb
	begin
		if (priv_hit)
			kind = VWAT_CPU_LOCAL;
		else if (csr_hit)
			kind = longword ? VWAT_CPU_CSR : VWAT_CPU_REJECT;
		else if (win_hit)
			kind = longword ? VWAT_CPU_VME : VWAT_CPU_REJECT;
		else
			kind = VWAT_CPU_NONE;
	end
endmodule : vwat_cpu_dec

// ### design/vwat_dma_dec.sv
// vme-side acceptance check and address translation for dma cycles
`timescale 1ns/1ps
`include "vwat_regs.svh"
module vwat_dma_dec
	import vwat_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [5:0] am,
	input vwat_mode_t mode,
	input wire logic ext_en,
	input wire logic std_en,
	output logic claim,
	output logic [39:0] sys_addr
);
	logic is_ext;
	logic is_std;
	logic is_short;

	assign is_short = (am == `VWAT_AM_SHORT_A) || (am == `VWAT_AM_SHORT_B);
	assign is_ext = (am[5:3] == `VWAT_AM_EXT_TOP);
	assign is_std = (am[5:3] == `VWAT_AM_STD_TOP);

	always_comb
	begin
		claim = 1'b0;
		sys_addr = 40'h00_0000_0000;
		// page-map modes have no map here, so nothing is claimed in them
		if (mode == VWAT_MODE_NONE && !is_short)
		begin
			if (is_ext && ext_en && addr[31:29] == 3'h0)
			begin
				claim = 1'b1;
				sys_addr = {11'h000, addr[28:0]};
			end
			else if (is_std && std_en && !addr[23])
			begin
				claim = 1'b1;
				sys_addr = {16'h0000, addr[23:0]};
			end
		end
	end
endmodule : vwat_dma_dec

// ### design/vwat_pkg.sv
// types shared by the window translator modules
package vwat_pkg;
	typedef enum logic [2:0] {
		VWAT_MODE_NONE = 3'h0,
		VWAT_MODE_34 = 3'h1,
		VWAT_MODE_40_512 = 3'h2,
		VWAT_MODE_40_4K = 3'h3,
		VWAT_MODE_40_8K = 3'h4
	} vwat_mode_t;
	typedef enum logic [2:0] {
		VWAT_CPU_NONE = 3'h0,
		VWAT_CPU_LOCAL = 3'h1,
		VWAT_CPU_CSR = 3'h2,
		VWAT_CPU_VME = 3'h3,
		VWAT_CPU_REJECT = 3'h4
	} vwat_cpu_kind_t;
	typedef struct packed {
		logic valid;
		logic longword;
		logic [31:0] addr;
	} vwat_cpu_req_t;
	typedef struct packed {
		logic valid;
		vwat_cpu_kind_t kind;
		logic [31:0] vme_addr;
		logic [1:0] addr_len;
		logic [1:0] data_len;
	} vwat_cpu_rsp_t;
	typedef struct packed {
		logic valid;
		logic [5:0] am;
		logic [31:0] addr;
	} vwat_dma_req_t;
	typedef struct packed {
		logic valid;
		logic claim;
		logic [39:0] sys_addr;
	} vwat_dma_rsp_t;
endpackage : vwat_pkg

// ### design/vwat_regs.svh
// register offsets, field positions, reset values and decode constants for the window translator
`ifndef VWAT_REGS_SVH
`define VWAT_REGS_SVH

`define VWAT_OFF_UTIL 12'h000
`define VWAT_OFF_RANGE 12'h004
`define VWAT_OFF_STAT 12'h008
`define VWAT_OFF_CNT 12'h00C
`define VWAT_OFF_WIN 12'h080
`define VWAT_UTIL_MODE_MSB 19
`define VWAT_UTIL_MODE_LSB 17
`define VWAT_UTIL_A30_BIT 0
`define VWAT_RANGE_EXT_BIT 0
`define VWAT_RANGE_STD_BIT 1
`define VWAT_WIN_HI_MSB 31
`define VWAT_WIN_HI_LSB 20
`define VWAT_WIN_AL_MSB 3
`define VWAT_WIN_AL_LSB 2
`define VWAT_WIN_DL_MSB 1
`define VWAT_WIN_DL_LSB 0
`define VWAT_UTIL_RESET 32'h0000_0000
`define VWAT_RANGE_RESET 32'h0000_0000
`define VWAT_WIN_RESET 32'h0000_0000
`define VWAT_PRIV_FIRST 9'h1C0
`define VWAT_PRIV_LAST 9'h1C2
`define VWAT_NODESP_BASE 13'h1C30
`define VWAT_WIN_BASE 7'h70
`define VWAT_AM_SHORT_A 6'h29
`define VWAT_AM_SHORT_B 6'h2D
`define VWAT_AM_EXT_TOP 3'h1
`define VWAT_AM_STD_TOP 3'h7

`endif

// ### design/vwat_top.sv
// window address translator: apb registers, cpu window decode and dma acceptance
`timescale 1ns/1ps
`include "vwat_regs.svh"
module vwat_top
	import vwat_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] node_id,
	input vwat_cpu_req_t cpu_req,
	output vwat_cpu_rsp_t cpu_rsp,
	input vwat_dma_req_t dma_req,
	output vwat_dma_rsp_t dma_rsp
);
	logic [31:0] util_q;
	logic [31:0] range_q;
	logic [31:0] cpu_window_offset_reg [0:31];
	logic [3:0] node_q;
	logic node_cap_q;
	logic [7:0] cpu_vme_cnt_q;
	logic [7:0] cpu_rej_cnt_q;
	logic [7:0] dma_claim_cnt_q;
	logic [7:0] dma_rej_cnt_q;
	logic cpu_rej_seen_q;
	logic dma_rej_seen_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	vwat_cpu_rsp_t cpu_rsp_q;
	vwat_dma_rsp_t dma_rsp_q;

	logic setup;
	logic wr_take;
	logic [31:0] rd_d;
	logic map_d;
	logic [31:0] wmask;
	logic win_sel;
	logic [4:0] win_idx;
	logic [31:0] cpu_addr_n;
	vwat_cpu_kind_t cpu_kind;
	logic [4:0] offs_sel;
	logic [31:0] offs_word;
	vwat_mode_t mode;
	logic dma_claim;
	logic [39:0] dma_sys_addr;
	logic cpu_vme_ev;
	logic cpu_rej_ev;
	logic dma_claim_ev;
	logic dma_rej_ev;
	logic cnt_clr;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cpu_rsp = cpu_rsp_q;
	assign dma_rsp = dma_rsp_q;

	// apb: setup edge prepares the answer, access phase always lasts one cycle
	assign setup = psel && !penable && !pready_q;
	assign wr_take = psel && penable && pready_q && pwrite && !pslverr_q;
	assign win_sel = (paddr[11:7] == 5'(`VWAT_OFF_WIN >> 7));
	assign win_idx = paddr[6:2];
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign cnt_clr = wr_take && (paddr == `VWAT_OFF_CNT);

	always_comb
	begin
		rd_d = 32'h0000_0000;
		map_d = 1'b1;
		if (paddr[1:0] != 2'h0)
			map_d = 1'b0;
		else if (win_sel)
			rd_d = cpu_window_offset_reg[win_idx];
		else if (paddr == `VWAT_OFF_UTIL)
			rd_d = util_q;
		else if (paddr == `VWAT_OFF_RANGE)
			rd_d = range_q;
		else if (paddr == `VWAT_OFF_STAT)
			rd_d = {22'h00_0000, dma_rej_seen_q, cpu_rej_seen_q, 1'b0, mode, node_q};
		else if (paddr == `VWAT_OFF_CNT)
			rd_d = {dma_rej_cnt_q, dma_claim_cnt_q, cpu_rej_cnt_q, cpu_vme_cnt_q};
		else
			map_d = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_q <= 1'b0;
		else
			pready_q <= setup;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr_q <= !map_d || (pwrite && paddr == `VWAT_OFF_STAT);
		end
		else if (pready_q)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			util_q <= `VWAT_UTIL_RESET;
		else if (wr_take && paddr == `VWAT_OFF_UTIL)
			util_q <= (util_q & ~wmask) | (pwdata & wmask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			range_q <= `VWAT_RANGE_RESET;
		else if (wr_take && paddr == `VWAT_OFF_RANGE)
			range_q <= (range_q & ~wmask) | (pwdata & wmask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 32; i++)
				cpu_window_offset_reg[i] <= `VWAT_WIN_RESET;
		end
		else if (wr_take && win_sel)
			cpu_window_offset_reg[win_idx] <= (cpu_window_offset_reg[win_idx] & ~wmask) | (pwdata & wmask);
	end

	// slot number is a strap; taken once after reset so a moving pin cannot shift the window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			node_q <= 4'h0;
			node_cap_q <= 1'b0;
		end
		else if (!node_cap_q)
		begin
			node_q <= node_id;
			node_cap_q <= 1'b1;
		end
	end

	// unknown mode codes fall back to the 34-bit page-map mode: nothing is claimed
	always_comb
	begin
		unique case (util_q[`VWAT_UTIL_MODE_MSB:`VWAT_UTIL_MODE_LSB])
			3'h0: mode = VWAT_MODE_NONE;
			3'h1: mode = VWAT_MODE_34;
			3'h2: mode = VWAT_MODE_40_512;
			3'h3: mode = VWAT_MODE_40_4K;
			3'h4: mode = VWAT_MODE_40_8K;
			default: mode = VWAT_MODE_34;
		endcase
	end

	// 30-bit hosts put 2 or 3 in the top digit; forcing bits 31:30 gives E or F
	assign cpu_addr_n = util_q[`VWAT_UTIL_A30_BIT] ? {2'h3, cpu_req.addr[29:0]} : cpu_req.addr;

	vwat_cpu_dec u_cpu_dec
	(
		.addr(cpu_addr_n),
		.longword(cpu_req.longword),
		.node(node_q),
		.kind(cpu_kind)
	);

	assign offs_sel = cpu_addr_n[24:20];
	assign offs_word = cpu_window_offset_reg[offs_sel];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cpu_rsp_q <= '0;
		else if (cpu_req.valid && node_cap_q)
		begin
			cpu_rsp_q.valid <= 1'b1;
			cpu_rsp_q.kind <= cpu_kind;
			if (cpu_kind == VWAT_CPU_VME)
			begin
				// section base from the register, byte offset from the host address
				cpu_rsp_q.vme_addr <= {offs_word[`VWAT_WIN_HI_MSB:`VWAT_WIN_HI_LSB], cpu_addr_n[19:0]};
				cpu_rsp_q.addr_len <= offs_word[`VWAT_WIN_AL_MSB:`VWAT_WIN_AL_LSB];
				cpu_rsp_q.data_len <= offs_word[`VWAT_WIN_DL_MSB:`VWAT_WIN_DL_LSB];
			end
			else if (cpu_kind == VWAT_CPU_CSR)
			begin
				cpu_rsp_q.vme_addr <= {13'h0000, cpu_addr_n[18:0]};
				cpu_rsp_q.addr_len <= 2'h0;
				cpu_rsp_q.data_len <= 2'h0;
			end
			else
			begin
				cpu_rsp_q.vme_addr <= 32'h0000_0000;
				cpu_rsp_q.addr_len <= 2'h0;
				cpu_rsp_q.data_len <= 2'h0;
			end
		end
		else
			cpu_rsp_q <= '0;
	end

	vwat_dma_dec u_dma_dec
	(
		.addr(dma_req.addr),
		.am(dma_req.am),
		.mode(mode),
		.ext_en(range_q[`VWAT_RANGE_EXT_BIT]),
		.std_en(range_q[`VWAT_RANGE_STD_BIT]),
		.claim(dma_claim),
		.sys_addr(dma_sys_addr)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dma_rsp_q <= '0;
		else
		begin
			dma_rsp_q.valid <= dma_req.valid;
			dma_rsp_q.claim <= dma_req.valid && dma_claim;
			dma_rsp_q.sys_addr <= (dma_req.valid && dma_claim) ? dma_sys_addr : 40'h00_0000_0000;
		end
	end

	assign cpu_vme_ev = cpu_rsp_q.valid && cpu_rsp_q.kind == VWAT_CPU_VME;
	assign cpu_rej_ev = cpu_rsp_q.valid && cpu_rsp_q.kind == VWAT_CPU_REJECT;
	assign dma_claim_ev = dma_rsp_q.valid && dma_rsp_q.claim;
	assign dma_rej_ev = dma_rsp_q.valid && !dma_rsp_q.claim;

	// a count that moves in the clearing cycle restarts at one, so no event is lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_vme_cnt_q <= 8'h00;
			cpu_rej_cnt_q <= 8'h00;
		end
		else if (cnt_clr)
		begin
			cpu_vme_cnt_q <= {7'h00, cpu_vme_ev};
			cpu_rej_cnt_q <= {7'h00, cpu_rej_ev};
		end
		else
		begin
			cpu_vme_cnt_q <= cpu_vme_cnt_q + {7'h00, cpu_vme_ev};
			cpu_rej_cnt_q <= cpu_rej_cnt_q + {7'h00, cpu_rej_ev};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dma_claim_cnt_q <= 8'h00;
			dma_rej_cnt_q <= 8'h00;
		end
		else if (cnt_clr)
		begin
			dma_claim_cnt_q <= {7'h00, dma_claim_ev};
			dma_rej_cnt_q <= {7'h00, dma_rej_ev};
		end
		else
		begin
			dma_claim_cnt_q <= dma_claim_cnt_q + {7'h00, dma_claim_ev};
			dma_rej_cnt_q <= dma_rej_cnt_q + {7'h00, dma_rej_ev};
		end
	end

	// sticky refusal flags; set beats clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_rej_seen_q <= 1'b0;
			dma_rej_seen_q <= 1'b0;
		end
		else
		begin
			cpu_rej_seen_q <= cpu_rej_ev || (cpu_rej_seen_q && !cnt_clr);
			dma_rej_seen_q <= dma_rej_ev || (dma_rej_seen_q && !cnt_clr);
		end
	end
endmodule : vwat_top
